// >>> hdl/irq_prio_pkg.sv
// Constants and carriers for the four-level interrupt priority controller.
// Assumes a single core clock and a special-function register port from
// the processor core.
package irq_prio_pkg;

    // ************************************************************
    // Register map and fields
    // ************************************************************
    localparam logic [7:0] irq_enable_addr = 8'hA8;
    localparam logic [7:0] prio_high_addr = 8'hB7;
    localparam logic [7:0] prio_low_addr = 8'hB8;
    localparam logic [7:0] irq_enable_reset = 8'h00;
    localparam logic [7:0] prio_reset = 8'h00;
    localparam int global_enable_bit = 7;
    localparam int num_sources = 6;
    localparam int num_levels = 4;
    localparam logic [7:0] irq_enable_mask = 8'hBF;
    localparam logic [7:0] prio_mask = 8'h3F;

    // Source indices in polling order
    localparam int src_pin_int0 = 0;
    localparam int src_tmr0 = 1;
    localparam int src_pin_int1 = 2;
    localparam int src_tmr1 = 3;
    localparam int src_serial = 4;
    localparam int src_tmr2 = 5;

    // Vectors are eight bytes apart from the first external source
    localparam logic [15:0] vector_base = 16'h0003;
    localparam int vector_shift = 3;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;

    typedef struct packed {
        logic valid;
        logic [2:0] source;
        logic [1:0] level;
        logic [15:0] vector;
    } dispatch_s;

endpackage

// >>> hdl/irq_level_pick.sv
// Finds the first requesting source, in polling order, on one level.
// Pure combinational; used once per priority level.
`timescale 1ns/1ns
module irq_level_pick (
    // Requests already qualified for this level
    input wire logic [5:0] req,
    // First source found
    output logic found,
    output logic [2:0] source
);

    always_comb begin
        found = 1'b0;
        source = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                source = 3'(i);
            end
        end
    end

endmodule

// >>> hdl/irq_prio_ctrl.sv
// Nested interrupt controller: six sources, four priority levels.
// Assumes the core acknowledges a dispatch in the cycle it vectors, and
// signals each return from an interrupt routine with a one-cycle pulse.
//
// What this block does
// - Six sources arbitrated across four levels
// - Level is high bit then low bit
// - Dispatch only above every level in service
// - Equal or lower request waits for return
// - Higher preempts; suspended routine resumes afterwards
// - Priority-high register at B7
// - Priority-high bits 5..0, bits 7..6 reserved
// - Priority-low register at B8, same order
// - Clear edge externals and timers 0/1
`timescale 1ns/1ns
module irq_prio_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Special-function register port
    input wire irq_prio_pkg::sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Request flags from peripherals, same clock
    input wire logic [5:0] src_flag,
    input wire logic pin_int0_edge_mode,
    input wire logic pin_int1_edge_mode,
    // Processor core
    output irq_prio_pkg::dispatch_s dispatch,
    input wire logic dispatch_ack,
    input wire logic irq_return,
    output logic [3:0] in_service,
    // Hardware flag clears on vectoring
    output logic pin_int0_flag_clr,
    output logic tmr0_overflow_flag_clr,
    output logic pin_int1_flag_clr,
    output logic tmr1_overflow_flag_clr
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] irq_enable_reg;
    logic [7:0] prio_high_reg;
    logic [7:0] prio_low_reg;
    logic [3:0] active_reg;
    logic [3:0] active_next;
    logic [5:0] req;
    logic [1:0] src_level [6];
    logic [3:0] lvl_found;
    logic [2:0] lvl_src [4];
    logic take;
    logic [1:0] win_level;
    logic [2:0] win_src;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_enable_reg <= irq_prio_pkg::irq_enable_reset;
            prio_high_reg <= irq_prio_pkg::prio_reset;
            prio_low_reg <= irq_prio_pkg::prio_reset;
        end else if (sfr_req.wr) begin
            case (sfr_req.addr)
                irq_prio_pkg::irq_enable_addr: begin
                    irq_enable_reg <= sfr_req.wdata &
                        irq_prio_pkg::irq_enable_mask;
                end
                irq_prio_pkg::prio_high_addr: begin
                    prio_high_reg <= sfr_req.wdata &
                        irq_prio_pkg::prio_mask;
                end
                irq_prio_pkg::prio_low_addr: begin
                    prio_low_reg <= sfr_req.wdata &
                        irq_prio_pkg::prio_mask;
                end
                default: begin
                end
            endcase
        end
    end

    // Reads of reserved bits return zero because they never store
    always_comb begin
        sfr_hit = 1'b1;
        case (sfr_req.addr)
            irq_prio_pkg::irq_enable_addr: sfr_rdata = irq_enable_reg;
            irq_prio_pkg::prio_high_addr: sfr_rdata = prio_high_reg;
            irq_prio_pkg::prio_low_addr: sfr_rdata = prio_low_reg;
            default: begin
                sfr_rdata = 8'h00;
                sfr_hit = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Arbitration
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < irq_prio_pkg::num_sources; g++) begin : g_src
            assign src_level[g] = {prio_high_reg[g], prio_low_reg[g]};
            assign req[g] = src_flag[g] & irq_enable_reg[g] &
                irq_enable_reg[irq_prio_pkg::global_enable_bit];
        end
        for (g = 0; g < irq_prio_pkg::num_levels; g++) begin : g_lvl
            logic [5:0] lreq;
            always_comb begin
                for (int s = 0; s < 6; s++) begin
                    lreq[s] = req[s] & (src_level[s] == 2'(g));
                end
            end
            irq_level_pick u_pick (
                .req(lreq),
                .found(lvl_found[g]),
                .source(lvl_src[g])
            );
        end
    endgenerate

    // Highest requesting level wins; it must sit above all in service
    always_comb begin
        take = 1'b0;
        win_level = 2'h0;
        win_src = 3'h0;
        for (int l = 0; l < 4; l++) begin
            if (lvl_found[l]) begin
                take = 1'b1;
                win_level = 2'(l);
                win_src = lvl_src[l];
            end
        end
        // Any active level at or above the winner blocks it
        if (take && ((active_reg >> win_level) != 4'h0)) begin
            take = 1'b0;
        end
    end

    always_comb begin
        dispatch.valid = take;
        dispatch.source = win_src;
        dispatch.level = win_level;
        dispatch.vector = irq_prio_pkg::vector_base +
            (16'(win_src) << irq_prio_pkg::vector_shift);
    end

    // ************************************************************
    // Service stack: one bit per level, return clears the highest
    // ************************************************************
    always_comb begin
        active_next = active_reg;
        if (irq_return) begin
            // Clearing only the top level lets a preempted one resume
            if (active_reg[3]) active_next[3] = 1'b0;
            else if (active_reg[2]) active_next[2] = 1'b0;
            else if (active_reg[1]) active_next[1] = 1'b0;
            else active_next[0] = 1'b0;
        end
        if (take && dispatch_ack) begin
            active_next[win_level] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            active_reg <= 4'h0;
        end else begin
            active_reg <= active_next;
        end
    end

    assign in_service = active_reg;

    // Serial and timer 2 flags are left for software
    always_comb begin
        pin_int0_flag_clr = take && dispatch_ack && pin_int0_edge_mode &&
            (win_src == 3'(irq_prio_pkg::src_pin_int0));
        pin_int1_flag_clr = take && dispatch_ack && pin_int1_edge_mode &&
            (win_src == 3'(irq_prio_pkg::src_pin_int1));
        tmr0_overflow_flag_clr = take && dispatch_ack &&
            (win_src == 3'(irq_prio_pkg::src_tmr0));
        tmr1_overflow_flag_clr = take && dispatch_ack &&
            (win_src == 3'(irq_prio_pkg::src_tmr1));
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence ack_s;
        dispatch.valid && dispatch_ack && !irq_return;
    endsequence

    property no_block_p;
        @(posedge core_clk) disable iff (!reset_n)
        dispatch.valid |-> ((in_service >> dispatch.level) == 4'h0);
    endproperty
    dispatch_above_a: assert property (no_block_p)
        else $error("dispatch while same or higher level active");

    level_mark_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        ack_s |=> in_service[$past(dispatch.level)])
        else $error("dispatched level not marked in service");

    vector_value_a: assert property (@(posedge core_clk)
        disable iff (!reset_n) dispatch.valid |->
        dispatch.vector == 16'h0003 + 16'(dispatch.source) * 16'h0008)
        else $error("vector address wrong");

    gated_enable_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        dispatch.valid |-> irq_enable_reg[7] &&
        irq_enable_reg[dispatch.source] && src_flag[dispatch.source])
        else $error("dispatch of disabled source");

    level_code_a: assert property (@(posedge core_clk)
        disable iff (!reset_n) dispatch.valid |-> dispatch.level ==
        {prio_high_reg[dispatch.source], prio_low_reg[dispatch.source]})
        else $error("level not taken from priority bits");

    prio_reserved_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        prio_high_reg[7:6] == 2'h0 && prio_low_reg[7:6] == 2'h0)
        else $error("reserved priority bits set");

    resume_lower_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        (irq_return && !dispatch_ack && in_service[3] && in_service[0])
        |=> in_service[0] && !in_service[3])
        else $error("return did not resume lower level");

    timer_clear_a: assert property (@(posedge core_clk)
        disable iff (!reset_n) (ack_s and
        (dispatch.source == 3'h1)) |-> tmr0_overflow_flag_clr)
        else $error("timer 0 flag not cleared on vectoring");

    hold_pending_a: assert property (@(posedge core_clk)
        disable iff (!reset_n) (in_service[3] && !irq_return)
        |-> !dispatch.valid)
        else $error("request not held while level 3 active");

endmodule

// >>> tb/core_model.sv
// Processor core stand-in: vectors dispatches and returns from routines.
// Assumes dispatch outputs of the controller settle within the cycle.
`timescale 1ns/1ns
module core_model (
    // Controller side
    input wire irq_prio_pkg::dispatch_s dispatch,
    input wire logic [3:0] in_service,
    output logic dispatch_ack,
    output logic irq_return,
    // Bench pacing: low take_en stalls vectoring, ret_go asks a return
    input wire logic take_en,
    input wire logic ret_go
);
    // A real core vectors only between instructions, hence the stall
    assign dispatch_ack = dispatch.valid && take_en;
    // No return is issued while no routine is in service
    assign irq_return = ret_go && (in_service != 4'h0);
endmodule

// >>> tb/four_level_interrupt_priority_bench.sv
// Self-checking bench of the interrupt priority controller.
// Assumes the core model in core_model.sv and the design package.
`timescale 1ns/1ns
module four_level_interrupt_priority_bench;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    irq_prio_pkg::sfr_req_s sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic sfr_hit;
    logic [5:0] src_flag = 6'h00;
    logic [1:0] edge_mode = 2'h0;
    irq_prio_pkg::dispatch_s dispatch;
    logic dispatch_ack;
    logic irq_return;
    logic take_en = 1'b0;
    logic ret_go = 1'b0;
    logic [3:0] in_service;
    logic [3:0] clr;
    logic [7:0] addrs [5] = '{8'hA8, 8'hB7, 8'hB8, 8'hA9, 8'h00};
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int regs [3];
    int isv = 0;

    irq_prio_ctrl i_irq_prio_ctrl (.core_clk(core_clk), .reset_n(reset_n),
        .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .src_flag(src_flag), .pin_int0_edge_mode(edge_mode[0]),
        .pin_int1_edge_mode(edge_mode[1]), .dispatch(dispatch),
        .dispatch_ack(dispatch_ack), .irq_return(irq_return),
        .in_service(in_service), .pin_int0_flag_clr(clr[0]),
        .tmr0_overflow_flag_clr(clr[1]), .pin_int1_flag_clr(clr[2]),
        .tmr1_overflow_flag_clr(clr[3]));
    core_model i_core_model (.dispatch(dispatch), .in_service(in_service),
        .dispatch_ack(dispatch_ack), .irq_return(irq_return),
        .take_en(take_en), .ret_go(ret_go));

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    // ************************************************************
    // Reference model
    // ************************************************************
    function automatic int lvl(int s);
        return 2 * ((regs[1] >> s) & 1) + ((regs[2] >> s) & 1);
    endfunction
    // Highest level wins, lowest index breaks ties; -1 when nobody asks
    function automatic int pick();
        int best = -1;
        for (int s = 0; s < 6; s++) begin
            if (((regs[0] >> s) & (regs[0] >> 7) & 1) && src_flag[s] &&
                (best < 0 || lvl(s) > lvl(best))) begin
                best = s;
            end
        end
        return best;
    endfunction
    function automatic int rd(logic [7:0] a);
        case (a)
            8'hA8: return regs[0];
            8'hB7: return regs[1];
            8'hB8: return regs[2];
            default: return 0;
        endcase
    endfunction

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (err_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge core_clk) begin
        int w;
        if (!reset_n) begin
            regs = '{0, 0, 0};
            isv = 0;
        end else begin
            w = pick();
            if (w >= 0 && take_en && (isv >> lvl(w)) == 0) begin
                // Return is taken first, so the new level lands after it
                if (irq_return)
                    isv = isv & ~(1 << $clog2(isv + 1) - 1);
                isv = isv | (1 << lvl(w));
            end else if (irq_return) begin
                isv = isv & ~(1 << $clog2(isv + 1) - 1);
            end
            if (sfr_req.wr) begin
                case (sfr_req.addr)
                    8'hA8: regs[0] = sfr_req.wdata & 8'hBF;
                    8'hB7: regs[1] = sfr_req.wdata & 8'h3F;
                    8'hB8: regs[2] = sfr_req.wdata & 8'h3F;
                    default: ;
                endcase
            end
        end
    end

    // Outputs are settled by the falling edge
    always @(negedge core_clk) begin
        int w;
        logic v;
        logic [3:0] e;
        if (reset_n) begin
            w = pick();
            v = (w >= 0) && ((isv >> lvl(w)) == 0);
            e = 4'h0;
            if (v && take_en && w < 4)
                e[w] = (w % 2 == 1) || edge_mode[w / 2];
            check("valid", dispatch.valid, v);
            if (v) begin
                check("source", dispatch.source, w);
                check("level", dispatch.level, lvl(w));
                check("vector", dispatch.vector, 3 + 8 * w);
            end
            check("in_service", in_service, isv);
            check("clears", clr, e);
            check("rdata", sfr_rdata, rd(sfr_req.addr));
            check("hit", sfr_hit,
                sfr_req.addr inside {8'hA8, 8'hB7, 8'hB8});
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 5000) begin
            err_count++;
            stop_test();
        end
    end

    // ************************************************************
    // Stimulus
    // ************************************************************
    initial begin
        void'($urandom(94993));
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        // Reset value, all ones with reserved bits, then two unmapped places
        foreach (addrs[i]) begin
            @(posedge core_clk);
            sfr_req <= '{1'b0, 1'b1, addrs[i], 8'h00};
            @(posedge core_clk);
            sfr_req <= '{1'b1, 1'b0, addrs[i], 8'hFF};
            @(posedge core_clk);
            sfr_req <= '{1'b0, 1'b1, addrs[i], 8'h00};
        end
        // Random traffic; stalls and returns build nested service stacks
        repeat (3000) begin
            @(posedge core_clk);
            src_flag <= 6'($urandom);
            edge_mode <= 2'($urandom);
            take_en <= ($urandom % 4) != 0;
            ret_go <= ($urandom % 5) == 0;
            if ($urandom % 12 == 0)
                sfr_req <= '{1'b1, 1'b0, addrs[$urandom % 5], 8'($urandom)};
            else
                sfr_req <= '{1'b0, 1'b1, addrs[$urandom % 5], 8'h00};
        end
        stop_test();
    end
endmodule
